// ---- mcie_exec.sv ----
// Operation
// - Indirect store writes accumulator, pointer pre/post updated
// - Offset store addresses pointer plus signed offset
// - Pointers are 16 bits and wrap
// - Pointer update and store change no flags
// - Indirect window redirects to pointer address
// - Option load copies accumulator, flags untouched
// - Software reset resets device, clears indicator
// - Interrupt return pops stack, sets global enable
// - Subroutine return pops stack, two cycles
// - Constant return loads accumulator and pops
// - Rotate left through carry only
// - Rotate right through carry only
// - Constant minus accumulator with carry, nibble flags
// - Register minus accumulator updates C, DC, Z
// - Subtract with borrow uses inverted carry
// - Sleep clears watchdog, sets expiry, clears powerdown
// - Nibble exchange swaps halves, no flags
// - XOR with constant updates zero only
// - Direction load selects port by operand 5..7
// - XOR with register updates zero only
//
// Purpose: Executes a subset of an 8-bit core's instructions
// Assumes: One command per start pulse; register file outside the block
// Notes: File data for the operand arrives with the command on file_rdata
module mcie_exec
    import mcie_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int PTR_W = 16,
    parameter int PC_W = 15
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // Command port
    input wire logic start,
    input wire mcie_pkg::mcie_op_type op,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] literal,
    input wire logic ptr_sel,
    input wire logic [1:0] pointer_update_code,
    input wire logic [5:0] offset,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic busy,
    output logic done,
    // Register file write port
    output logic file_we,
    output logic file_ind,
    output logic [PTR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    // Stack and program counter
    input wire logic [PC_W-1:0] stack_top,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] instr_pointer,
    // Watchdog, oscillator and reset
    output logic wdt_clear,
    output logic osc_stop,
    input wire logic wake,
    output logic dev_reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import mcie_pkg::*;

    // Reset synchroniser
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Architectural state
    logic [DATA_W-1:0] acc_r;
    logic flag_c_r, flag_dc_r, flag_z_r;
    logic expiry_flag_r, powerdown_flag_r;
    logic [PTR_W-1:0] ptr_r [2]; // Two indirect pointers
    logic [DATA_W-1:0] option_r;
    logic [DATA_W-1:0] port_a_direction_r, port_b_direction_r, port_c_direction_r;
    logic sw_reset_indicator_n_r;
    logic [DATA_W-1:0] irq_ctl_r;
    mcie_state_type state_r, state_nxt;
    logic [1:0] swrst_cnt_r; // Software reset pulse timer
    logic [PC_W-1:0] pc_r;

    // Command decode
    wire is_start = start && (state_r == MCIE_ST_IDLE);
    wire is_ind = (op == MCIE_OP_STORE_IND);
    wire is_ofs = (op == MCIE_OP_STORE_OFS);
    wire is_pop = (op == MCIE_OP_IRQ_RET) || (op == MCIE_OP_RET) || (op == MCIE_OP_RET_CONST);

    // Pointer arithmetic; natural 16-bit wrap
    wire [PTR_W-1:0] ptr_cur = ptr_r[ptr_sel];
    wire [PTR_W-1:0] ptr_inc = ptr_cur + PTR_W'(1);
    wire [PTR_W-1:0] ptr_dec = ptr_cur - PTR_W'(1);
    wire upd_inc = !pointer_update_code[0];
    wire upd_pre = !pointer_update_code[1];
    wire [PTR_W-1:0] ptr_upd = upd_inc ? ptr_inc : ptr_dec;
    wire [PTR_W-1:0] ofs_ext = PTR_W'($signed(offset));
    wire [PTR_W-1:0] ptr_ofs = ptr_cur + ofs_ext;
    // Effective address: pre modes use updated pointer, post use current
    wire [PTR_W-1:0] ind_addr = is_ofs ? ptr_ofs : (upd_pre ? ptr_upd : ptr_cur);

    // ALU
    wire [8:0] sub_const = {1'b0, literal} - {1'b0, acc_r};
    wire [8:0] sub_reg = {1'b0, file_rdata} - {1'b0, acc_r};
    wire [8:0] sub_regb = {1'b0, file_rdata} - {1'b0, acc_r} - {8'h00, !flag_c_r};
    wire [4:0] nib_const = {1'b0, literal[3:0]} - {1'b0, acc_r[3:0]};
    wire [4:0] nib_reg = {1'b0, file_rdata[3:0]} - {1'b0, acc_r[3:0]};
    wire [4:0] nib_regb = {1'b0, file_rdata[3:0]} - {1'b0, acc_r[3:0]} - {4'h0, !flag_c_r};
    wire [DATA_W-1:0] rot_l = {file_rdata[6:0], flag_c_r};
    wire [DATA_W-1:0] rot_r = {flag_c_r, file_rdata[7:1]};
    wire [DATA_W-1:0] swp = {file_rdata[3:0], file_rdata[7:4]};
    wire [DATA_W-1:0] xor_c = acc_r ^ literal;
    wire [DATA_W-1:0] xor_f = acc_r ^ file_rdata;

    // Result, flag updates and destination per operation
    logic [DATA_W-1:0] res;
    logic upd_c, upd_dc, upd_z, new_c, new_dc, res_to_file, res_to_acc;
    always_comb begin
        res = acc_r;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        new_c = flag_c_r;
        new_dc = flag_dc_r;
        res_to_file = 1'b0;
        res_to_acc = 1'b0;
        case (op)
            MCIE_OP_ROT_L: begin
                res = rot_l;
                upd_c = 1'b1;
                new_c = file_rdata[7];
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_ROT_R: begin
                res = rot_r;
                upd_c = 1'b1;
                new_c = file_rdata[0];
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_CONST_SUB: begin
                // No borrow out means acc <= literal
                res = sub_const[7:0];
                {upd_c, upd_dc, upd_z} = 3'b111;
                new_c = !sub_const[8];
                new_dc = !nib_const[4];
                res_to_acc = 1'b1;
            end
            MCIE_OP_REG_SUB: begin
                res = sub_reg[7:0];
                {upd_c, upd_dc, upd_z} = 3'b111;
                new_c = !sub_reg[8];
                new_dc = !nib_reg[4];
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_REG_SUBB: begin
                res = sub_regb[7:0];
                {upd_c, upd_dc, upd_z} = 3'b111;
                new_c = !sub_regb[8];
                new_dc = !nib_regb[4];
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_NIB_SWAP: begin
                res = swp;
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_XOR_CONST: begin
                res = xor_c;
                upd_z = 1'b1;
                res_to_acc = 1'b1;
            end
            MCIE_OP_XOR_REG: begin
                res = xor_f;
                upd_z = 1'b1;
                res_to_acc = !dest_sel;
                res_to_file = dest_sel;
            end
            MCIE_OP_RET_CONST: begin
                res = literal;
                res_to_acc = 1'b1;
            end
            default: begin
                // Remaining commands leave the data path alone
                res = acc_r;
            end
        endcase
    end

    wire exec_fire = is_start; // Every command executes on its start cycle
    wire new_z = (res == MCIE_RST_BYTE);
    wire dir_ok = (file_addr >= MCIE_DIR_PORT_A) && (file_addr <= MCIE_DIR_PORT_C);

    // File write port, combinational with the command
    assign file_we = exec_fire && (res_to_file || is_ind || is_ofs);
    assign file_ind = exec_fire && (is_ind || is_ofs);
    assign file_waddr = (is_ind || is_ofs) ? ind_addr : PTR_W'(file_addr);
    assign file_wdata = (is_ind || is_ofs) ? acc_r : res;

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MCIE_ST_IDLE: begin
                if (is_start && is_pop) state_nxt = MCIE_ST_POP2;
                else if (is_start && op == MCIE_OP_SLEEP) state_nxt = MCIE_ST_SLEEP;
            end
            MCIE_ST_POP2: state_nxt = MCIE_ST_IDLE; // Second cycle of a return
            MCIE_ST_SLEEP: if (wake) state_nxt = MCIE_ST_IDLE;
            default: state_nxt = MCIE_ST_IDLE;
        endcase
    end

    // APB decode; zero wait states
    wire apb_wr = psel && penable && pwrite;
    wire hit_acc = (paddr == MCIE_ADDR_ACC);
    wire hit_flags = (paddr == MCIE_ADDR_FLAGS);
    wire hit_p0 = (paddr == MCIE_ADDR_PTR0);
    wire hit_p1 = (paddr == MCIE_ADDR_PTR1);
    wire hit_opt = (paddr == MCIE_ADDR_OPTION);
    wire hit_dir = (paddr == MCIE_ADDR_DIR);
    wire hit_pwr = (paddr == MCIE_ADDR_PWR);
    wire hit_irq = (paddr == MCIE_ADDR_IRQCTL);
    wire hit_any = hit_acc | hit_flags | hit_p0 | hit_p1 | hit_opt | hit_dir | hit_pwr | hit_irq;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any; // Unmapped access errors
    wire [4:0] flag_vec = {expiry_flag_r, powerdown_flag_r, flag_z_r, flag_dc_r, flag_c_r};
    assign prdata = !(psel && !pwrite) ? MCIE_ZERO32 :
                    hit_acc ? {24'h00_0000, acc_r} :
                    hit_flags ? {27'h000_0000, flag_vec} :
                    hit_p0 ? {16'h0000, ptr_r[0]} :
                    hit_p1 ? {16'h0000, ptr_r[1]} :
                    hit_opt ? {24'h00_0000, option_r} :
                    hit_dir ? {8'h00, port_c_direction_r, port_b_direction_r, port_a_direction_r} :
                    hit_pwr ? {31'h0000_0000, sw_reset_indicator_n_r} :
                    hit_irq ? {24'h00_0000, irq_ctl_r} : MCIE_ZERO32;

    // Core sequencing, software reset timer and PC
    // Software reset drives the device reset low for a short pulse
    always_ff @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            state_r <= MCIE_ST_IDLE;
            swrst_cnt_r <= 2'h0;
            pc_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (exec_fire && op == MCIE_OP_SWRESET) swrst_cnt_r <= MCIE_SWRST_CYC;
            else if (swrst_cnt_r != 2'h0) swrst_cnt_r <= swrst_cnt_r - 2'h1;
            if (exec_fire && is_pop) pc_r <= stack_top;
        end
    end

    // Accumulator and arithmetic flags; power flags
    always_ff @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            acc_r <= MCIE_RST_BYTE;
            {flag_c_r, flag_dc_r, flag_z_r} <= 3'b000;
            expiry_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b1;
        end else if (apb_wr && hit_acc) begin
            acc_r <= pwdata[7:0];
        end else if (apb_wr && hit_flags) begin
            {expiry_flag_r, powerdown_flag_r, flag_z_r, flag_dc_r, flag_c_r} <= pwdata[4:0];
        end else if (exec_fire) begin
            // Store, NOP, option, direction and returns keep flags
            if (res_to_acc) acc_r <= res;
            if (upd_c) flag_c_r <= new_c;
            if (upd_dc) flag_dc_r <= new_dc;
            if (upd_z) flag_z_r <= new_z;
            if (op == MCIE_OP_SLEEP) begin
                expiry_flag_r <= 1'b1;
                powerdown_flag_r <= 1'b0;
            end
        end
    end

    // Indirect pointers; offset form leaves pointer unchanged
    always_ff @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ptr_r[0] <= MCIE_RST_PTR;
            ptr_r[1] <= MCIE_RST_PTR;
        end else if (apb_wr && (hit_p0 || hit_p1)) begin
            ptr_r[hit_p1] <= pwdata[15:0];
        end else if (exec_fire && is_ind) begin
            ptr_r[ptr_sel] <= ptr_upd;
        end
    end

    // Option, direction, power and interrupt control registers
    // Indicator is not reset by the software reset itself, so it survives
    always_ff @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            option_r <= MCIE_RST_OPTION;
            port_a_direction_r <= MCIE_RST_DIR;
            port_b_direction_r <= MCIE_RST_DIR;
            port_c_direction_r <= MCIE_RST_DIR;
            sw_reset_indicator_n_r <= 1'b1;
            irq_ctl_r <= MCIE_RST_BYTE;
        end else if (apb_wr) begin
            if (hit_opt) option_r <= pwdata[7:0];
            if (hit_pwr) sw_reset_indicator_n_r <= pwdata[0];
            if (hit_irq) irq_ctl_r <= pwdata[7:0];
            if (hit_dir) begin
                port_a_direction_r <= pwdata[7:0];
                port_b_direction_r <= pwdata[15:8];
                port_c_direction_r <= pwdata[23:16];
            end
        end else if (exec_fire) begin
            if (op == MCIE_OP_OPTION) option_r <= acc_r;
            if (op == MCIE_OP_SWRESET) sw_reset_indicator_n_r <= 1'b0;
            if (op == MCIE_OP_IRQ_RET) irq_ctl_r[MCIE_GIE_BIT] <= 1'b1;
            if (op == MCIE_OP_PIN_DIR && dir_ok) begin
                if (file_addr == MCIE_DIR_PORT_A) port_a_direction_r <= acc_r;
                if (file_addr == MCIE_DIR_PORT_B) port_b_direction_r <= acc_r;
                if (file_addr == MCIE_DIR_PORT_C) port_c_direction_r <= acc_r;
            end
        end
    end

    // Outputs
    assign busy = (state_r != MCIE_ST_IDLE);
    assign done = (state_r == MCIE_ST_POP2) || (exec_fire && !is_pop && op != MCIE_OP_SLEEP);
    assign stack_pop = exec_fire && is_pop;
    assign pc_load = (state_r == MCIE_ST_POP2);
    assign instr_pointer = pc_r;
    assign wdt_clear = exec_fire && (op == MCIE_OP_SLEEP);
    assign osc_stop = (state_r == MCIE_ST_SLEEP);
    assign dev_reset_n = (swrst_cnt_r == 2'h0);

    // Assertions
    chk_ret_two_cycle: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        stack_pop |=> (pc_load && busy && instr_pointer == $past(stack_top)) ##1 !busy)
        else $error("return did not finish in two cycles");
    chk_gie_set: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && op == MCIE_OP_IRQ_RET && !apb_wr) |=> irq_ctl_r[MCIE_GIE_BIT])
        else $error("global enable not set by interrupt return");
    chk_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && is_ind && !apb_wr && upd_inc && ptr_cur == 16'hffff)
        |=> ptr_r[$past(ptr_sel)] == 16'h0000)
        else $error("pointer did not wrap");
    chk_ofs_keep: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && is_ofs && !apb_wr) |=> $stable(ptr_r[0]) && $stable(ptr_r[1]))
        else $error("offset store changed a pointer");
    chk_store_flags: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && (is_ind || is_ofs) && !apb_wr) |=> $stable(flag_vec))
        else $error("indirect store changed flags");
    chk_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && upd_z && !apb_wr) |=> flag_z_r == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    chk_rot_carry: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && op == MCIE_OP_ROT_L && !apb_wr) |=> flag_c_r == $past(file_rdata[7]))
        else $error("rotate left carry wrong");
    chk_sleep_flags: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (wdt_clear && !apb_wr) |=> expiry_flag_r && !powerdown_flag_r && osc_stop)
        else $error("sleep entry flags wrong");
    chk_swrst_pulse: assert property (@(posedge ref_clk) disable iff (!rst_s2_r)
        (exec_fire && op == MCIE_OP_SWRESET) |=> !dev_reset_n[*2] ##1 dev_reset_n)
        else $error("software reset pulse wrong");
    cov_ret: cover property (@(posedge ref_clk) disable iff (!rst_s2_r) stack_pop ##1 pc_load);
    cov_sleep: cover property (@(posedge ref_clk) disable iff (!rst_s2_r) osc_stop ##1 !osc_stop);
    cov_store: cover property (@(posedge ref_clk) disable iff (!rst_s2_r) file_we && file_ind);
endmodule : mcie_exec

// ---- mcie_pkg.sv ----
// Purpose: Shared constants and types for the instruction execution block
// Assumes: 8-bit data path, 16-bit indirect pointers, APB register access
// Notes: Opcode values are block-local encodings on the command port
package mcie_pkg;
    // Command codes presented on the op port
    typedef enum logic [4:0] {
        MCIE_OP_NOP       = 5'h00,
        MCIE_OP_STORE_IND = 5'h01,
        MCIE_OP_STORE_OFS = 5'h02,
        MCIE_OP_OPTION    = 5'h03,
        MCIE_OP_SWRESET   = 5'h04,
        MCIE_OP_IRQ_RET   = 5'h05,
        MCIE_OP_RET       = 5'h06,
        MCIE_OP_RET_CONST = 5'h07,
        MCIE_OP_ROT_L     = 5'h08,
        MCIE_OP_ROT_R     = 5'h09,
        MCIE_OP_CONST_SUB = 5'h0a,
        MCIE_OP_REG_SUB   = 5'h0b,
        MCIE_OP_REG_SUBB  = 5'h0c,
        MCIE_OP_SLEEP     = 5'h0d,
        MCIE_OP_NIB_SWAP  = 5'h0e,
        MCIE_OP_XOR_CONST = 5'h0f,
        MCIE_OP_PIN_DIR   = 5'h10,
        MCIE_OP_XOR_REG   = 5'h11
    } mcie_op_type;

    // Execution states, Gray coded along the usual path
    typedef enum logic [1:0] {
        MCIE_ST_IDLE = 2'b00,
        MCIE_ST_EXEC = 2'b11,
        MCIE_ST_POP2 = 2'b01,
        MCIE_ST_SLEEP = 2'b10
    } mcie_state_type;

    // Pointer update codes
    localparam logic [1:0] MCIE_UPD_PRE_INC = 2'b00;
    localparam logic [1:0] MCIE_UPD_PRE_DEC = 2'b01;
    localparam logic [1:0] MCIE_UPD_POST_INC = 2'b10;

    // Direction-load operand values
    localparam logic [6:0] MCIE_DIR_PORT_A = 7'h05;
    localparam logic [6:0] MCIE_DIR_PORT_B = 7'h06;
    localparam logic [6:0] MCIE_DIR_PORT_C = 7'h07;

    // Interrupt control global enable position
    localparam int MCIE_GIE_BIT = 7;

    // APB register byte addresses
    localparam logic [7:0] MCIE_ADDR_ACC = 8'h00;
    localparam logic [7:0] MCIE_ADDR_FLAGS = 8'h04;
    localparam logic [7:0] MCIE_ADDR_PTR0 = 8'h08;
    localparam logic [7:0] MCIE_ADDR_PTR1 = 8'h0c;
    localparam logic [7:0] MCIE_ADDR_OPTION = 8'h10;
    localparam logic [7:0] MCIE_ADDR_DIR = 8'h14;
    localparam logic [7:0] MCIE_ADDR_PWR = 8'h18;
    localparam logic [7:0] MCIE_ADDR_IRQCTL = 8'h1c;

    // Flag positions in the flags register
    localparam int MCIE_FLAG_C = 0;
    localparam int MCIE_FLAG_DC = 1;
    localparam int MCIE_FLAG_Z = 2;
    localparam int MCIE_FLAG_PD = 3;
    localparam int MCIE_FLAG_TO = 4;

    // Reset values
    localparam logic [7:0] MCIE_RST_BYTE = 8'h00;
    localparam logic [7:0] MCIE_RST_OPTION = 8'hff;
    localparam logic [7:0] MCIE_RST_DIR = 8'hff;
    localparam logic [15:0] MCIE_RST_PTR = 16'h0000;
    localparam logic [31:0] MCIE_ZERO32 = 32'h0000_0000;

    // Software reset pulse length in clocks
    localparam logic [1:0] MCIE_SWRST_CYC = 2'h2;
endpackage : mcie_pkg

// ---- mcu_core_instruction_exec_test.sv ----
// Purpose: Self-checking bench for the instruction execution block
// Assumes: Zero-wait APB; flags {expiry,powerdown,zero,nibble,carry} at bits 4..0
// Notes: Driver queues expected results, a monitor pops them as results appear
module mcu_core_instruction_exec_test import mcie_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, start = 0, dest_sel = 0, ptr_sel = 0, wake = 0;
    logic psel = 0, penable = 0, pwrite = 0, busy, done, file_we, file_ind, stack_pop;
    logic pc_load, wdt_clear, osc_stop, dev_reset_n, pready, pslverr;
    mcie_op_type op = MCIE_OP_NOP;
    logic [6:0] file_addr = 0;
    logic [7:0] literal = 0, file_rdata = 0, paddr = 0, file_wdata, a, k, r;
    logic [1:0] pointer_update_code = 0;
    logic [5:0] offset = 0;
    logic [14:0] stack_top = 0, instr_pointer;
    logic [15:0] file_waddr;
    logic [31:0] pwdata = 0, prdata;
    logic [31:0] q_rd[$], q_wr[$], q_pc[$];
    int n_fail = 0, samples_checked = 0, cyc = 0;
    int n_pop = 0, n_wdt = 0, n_rst = 0, n_osc = 0, n_done = 0, n_busy = 0;
    mcie_exec u_dut (.ref_clk, .rst_n, .start, .op, .file_addr, .dest_sel, .literal, .ptr_sel,
        .pointer_update_code, .offset, .file_rdata, .busy, .done, .file_we, .file_ind,
        .file_waddr, .file_wdata, .stack_top, .stack_pop, .pc_load, .instr_pointer, .wdt_clear,
        .osc_stop, .wake, .dev_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    // Free-running 125 MHz clock
    always #4 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("Checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // Empty queue yields unknown so a surplus result counts as a mismatch
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 32'hxxxx_xxxx;
    endfunction : pop
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    // Monitor sees pre-edge values, so results are judged where they are settled
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk(pop(q_rd), prdata);
        if (file_we === 1'b1) chk(pop(q_wr), {7'h00, file_ind, file_waddr, file_wdata});
        if (pc_load === 1'b1) chk(pop(q_pc), {17'h0_0000, instr_pointer});
        if (psel && penable) chk(32'(paddr == 8'h40), 32'(pslverr));
        // Pulse and level counts, judged once at the end
        n_pop += (stack_pop === 1'b1);
        n_wdt += (wdt_clear === 1'b1);
        n_rst += (dev_reset_n === 1'b0);
        n_osc += (osc_stop === 1'b1);
        n_done += (done === 1'b1);
        n_busy += (busy === 1'b1);
        cyc++;
        if (cyc > 6000) begin
            n_fail++;
            print_verdict();
        end
    end
    // One APB transfer; held until pready is seen high in the access phase
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        // Idle edge so the next call never re-raises psel in this step
        @(posedge ref_clk);
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        q_rd.push_back(e);
        apb(1'b0, ad, 32'h0000_0000);
    endtask : rd
    task automatic run(input mcie_op_type o, input logic d, input logic [7:0] kl,
        input logic [7:0] f);
        start <= 1;
        op <= o;
        file_addr <= 7'h7f;
        dest_sel <= d;
        literal <= kl;
        file_rdata <= f;
        @(posedge ref_clk);
        start <= 0;
        repeat (2) @(posedge ref_clk);
    endtask : run
    // Register-operand op with preset carry and accumulator
    task automatic regop(input mcie_op_type o, input logic d, input logic [7:0] w,
        input logic c, input logic [7:0] f, input logic [7:0] res, input logic [31:0] fe);
        apb(1'b1, MCIE_ADDR_FLAGS, 32'h0000_0018 | 32'(c));
        apb(1'b1, MCIE_ADDR_ACC, {24'h00_0000, w});
        if (d) q_wr.push_back({8'h00, 16'h007f, res});
        run(o, d, 8'h00, f);
        if (!d) rd(MCIE_ADDR_ACC, {24'h00_0000, res});
        rd(MCIE_ADDR_FLAGS, fe);
    endtask : regop
    function automatic logic [31:0] fx(input logic z, input logic dc, input logic c);
        return {27'h000_0000, 2'b11, z, dc, c};
    endfunction : fx
    initial begin
        void'($urandom(87));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        rd(MCIE_ADDR_OPTION, 32'h0000_00ff);
        rd(MCIE_ADDR_DIR, 32'h00ff_ffff);
        rd(8'h40, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            k = (i == 0) ? a : 8'($urandom);
            r = k - a;
            apb(1'b1, MCIE_ADDR_FLAGS, 32'h0000_0018);
            apb(1'b1, MCIE_ADDR_ACC, {24'h00_0000, a});
            run(MCIE_OP_CONST_SUB, 1'b0, k, 8'h00);
            rd(MCIE_ADDR_ACC, {24'h00_0000, r});
            rd(MCIE_ADDR_FLAGS, fx(r == 0, a[3:0] <= k[3:0], a <= k));
            run(MCIE_OP_XOR_CONST, 1'b0, k, 8'h00);
            rd(MCIE_ADDR_ACC, {24'h00_0000, r ^ k});
            rd(MCIE_ADDR_FLAGS, fx((r ^ k) == 0, a[3:0] <= k[3:0], a <= k));
        end
        regop(MCIE_OP_ROT_L, 1'b0, 8'h00, 1'b0, 8'he6, 8'hcc, 32'h0000_0019);
        regop(MCIE_OP_ROT_R, 1'b1, 8'h00, 1'b1, 8'h01, 8'h80, 32'h0000_0019);
        regop(MCIE_OP_REG_SUB, 1'b1, 8'h05, 1'b0, 8'h05, 8'h00, 32'h0000_001f);
        regop(MCIE_OP_REG_SUB, 1'b0, 8'h06, 1'b0, 8'h05, 8'hff, 32'h0000_0018);
        regop(MCIE_OP_REG_SUBB, 1'b0, 8'h01, 1'b0, 8'h05, 8'h03, 32'h0000_001b);
        regop(MCIE_OP_REG_SUBB, 1'b1, 8'h00, 1'b1, 8'h00, 8'h00, 32'h0000_001f);
        regop(MCIE_OP_XOR_REG, 1'b0, 8'hff, 1'b1, 8'hff, 8'h00, 32'h0000_001d);
        regop(MCIE_OP_NIB_SWAP, 1'b1, 8'h00, 1'b1, 8'ha5, 8'h5a, 32'h0000_0019);
        // Pointer wraps at both ends; table of code, address, pointer after
        apb(1'b1, MCIE_ADDR_FLAGS, 32'h0000_0007);
        apb(1'b1, MCIE_ADDR_ACC, 32'h0000_005a);
        apb(1'b1, MCIE_ADDR_PTR0, 32'h0000_ffff);
        for (int i = 0; i < 4; i++) begin
            automatic logic [1:0] cd[4] = '{2'b00, 2'b11, 2'b01, 2'b10};
            automatic logic [15:0] ea[4] = '{16'h0000, 16'h0000, 16'hfffe, 16'hfffe};
            automatic logic [15:0] pa[4] = '{16'h0000, 16'hffff, 16'hfffe, 16'hffff};
            ptr_sel <= 0;
            pointer_update_code <= cd[i];
            q_wr.push_back({8'h01, ea[i], 8'h5a});
            run(MCIE_OP_STORE_IND, 1'b0, 8'h00, 8'h00);
            rd(MCIE_ADDR_PTR0, {16'h0000, pa[i]});
        end
        ptr_sel <= 1;
        apb(1'b1, MCIE_ADDR_PTR1, 32'h0000_0010);
        offset <= 6'h20;
        q_wr.push_back(32'h01ff_f05a);
        run(MCIE_OP_STORE_OFS, 1'b0, 8'h00, 8'h00);
        offset <= 6'h1f;
        q_wr.push_back(32'h0100_2f5a);
        run(MCIE_OP_STORE_OFS, 1'b0, 8'h00, 8'h00);
        rd(MCIE_ADDR_PTR1, 32'h0000_0010);
        rd(MCIE_ADDR_FLAGS, 32'h0000_0007);
        run(MCIE_OP_NOP, 1'b0, 8'h00, 8'h00);
        rd(MCIE_ADDR_ACC, 32'h0000_005a);
        // Returns load the program counter from a random stack top
        stack_top <= 15'($urandom);
        @(posedge ref_clk);
        q_pc.push_back({17'h0_0000, stack_top});
        run(MCIE_OP_RET, 1'b0, 8'h00, 8'h00);
        q_pc.push_back({17'h0_0000, stack_top});
        run(MCIE_OP_RET_CONST, 1'b0, 8'h77, 8'h00);
        rd(MCIE_ADDR_ACC, 32'h0000_0077);
        apb(1'b1, MCIE_ADDR_IRQCTL, 32'h0000_0000);
        q_pc.push_back({17'h0_0000, stack_top});
        run(MCIE_OP_IRQ_RET, 1'b0, 8'h00, 8'h00);
        rd(MCIE_ADDR_IRQCTL, 32'h0000_0080);
        rd(MCIE_ADDR_FLAGS, 32'h0000_0007);
        apb(1'b1, MCIE_ADDR_ACC, 32'h0000_004f);
        run(MCIE_OP_OPTION, 1'b0, 8'h00, 8'h00);
        rd(MCIE_ADDR_OPTION, 32'h0000_004f);
        for (int i = 5; i < 8; i++) begin
            apb(1'b1, MCIE_ADDR_ACC, 32'(8'h11 * (i - 4)));
            start <= 1;
            op <= MCIE_OP_PIN_DIR;
            file_addr <= 7'(i);
            @(posedge ref_clk);
            start <= 0;
            repeat (2) @(posedge ref_clk);
        end
        rd(MCIE_ADDR_DIR, 32'h0033_2211);
        // Sleep holds until wake; status bits checked afterwards
        apb(1'b1, MCIE_ADDR_FLAGS, 32'h0000_0008);
        run(MCIE_OP_SLEEP, 1'b0, 8'h00, 8'h00);
        wake <= 1;
        @(posedge ref_clk);
        wake <= 0;
        repeat (2) @(posedge ref_clk);
        rd(MCIE_ADDR_FLAGS, 32'h0000_0010);
        rd(MCIE_ADDR_PWR, 32'h0000_0001);
        run(MCIE_OP_SWRESET, 1'b0, 8'h00, 8'h00);
        repeat (4) @(posedge ref_clk);
        rd(MCIE_ADDR_PWR, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        // Three pops, one sleep entry, two reset-low cycles, three sleep cycles
        chk({8'd3, 8'd1, 8'd2, 8'd3}, {8'(n_pop), 8'(n_wdt), 8'(n_rst), 8'(n_osc)});
        // 35 completions; busy only in return second cycles and sleep
        chk({16'd35, 16'd6}, {16'(n_done), 16'(n_busy)});
        chk(0, q_rd.size() + q_wr.size() + q_pc.size());
        print_verdict();
    end
endmodule : mcu_core_instruction_exec_test
